/* File: core/pm_entry_fsm.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_entry_fsm (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Role and policy
    input wire logic is_upstream_i,
    input wire logic aspm_l1_enable_i,
    input wire logic can_accept_l1_i,
    input wire logic pcipm_l1_req_i,
    input wire logic l23_req_i,
    // Physical layer status
    input wire logic [2:0] ltssm_i,
    input wire logic link_up_i,
    input wire logic recovery_irq_i,
    input wire logic fundamental_reset_i,
    input wire logic link_idle_i,
    input wire logic rx_l0s_i,
    input wire logic tx_l0s_i,
    input wire logic l1_reached_i,
    input wire logic exit_done_i,
    // Received DLLPs
    input wire logic rx_enter_l1_i,
    input wire logic rx_aspm_req_l1_i,
    input wire logic rx_enter_l23_i,
    input wire logic rx_request_ack_i,
    input wire logic rx_aspm_nak_i,
    // Transaction layer
    input wire logic tlp_pending_i,
    output logic tlp_go_o,
    // Retrain control, upstream components only
    input wire logic retrain_write_i,
    output logic retrain_o,
    // Transmitted DLLPs
    output logic tx_enter_l1_o,
    output logic tx_aspm_req_l1_o,
    output logic tx_enter_l23_o,
    output logic tx_request_ack_o,
    output logic tx_aspm_nak_o,
    // Status
    output logic start_exit_o,
    output logic [3:0] pwr_state_o,
    output logic [6:0] neg_state_o
);

    pm_entry_pkg::neg_state_type state, next_state;
    pm_entry_pkg::pwr_state_type pwr, next_pwr;
    logic aspm_mode, next_aspm_mode;
    logic tlp_held, next_tlp_held;
    logic idle_expired, l0s_expired;

    // Link-level L0 includes Recovery, and Configuration while up
    wire in_l0 = (ltssm_i == pm_entry_pkg::PHY_L0) ||
                 (ltssm_i == pm_entry_pkg::PHY_RECOVERY) ||
                 ((ltssm_i == pm_entry_pkg::PHY_CONFIG) && link_up_i);
    wire goto_ldn = fundamental_reset_i || (ltssm_i == pm_entry_pkg::PHY_HOT_RESET) ||
                    (ltssm_i == pm_entry_pkg::PHY_DISABLED);
    // Recovery trip aborts any negotiation in flight
    wire interrupted = recovery_irq_i;
    wire negotiating = (state == pm_entry_pkg::NEG_SEND_L1) ||
                       (state == pm_entry_pkg::NEG_SEND_L23) ||
                       (state == pm_entry_pkg::NEG_ACK_WAIT);
    wire down = !is_upstream_i;
    wire auto_l1 = aspm_l1_enable_i && (idle_expired || l0s_expired);
    wire down_start_l1 = down && (pcipm_l1_req_i || auto_l1);
    wire down_start_l23 = down && l23_req_i;
    wire up_rx_aspm = is_upstream_i && rx_aspm_req_l1_i;
    wire up_rx_pm = is_upstream_i && (rx_enter_l1_i || rx_enter_l23_i);
    // Upstream rejects at once when it cannot accept
    wire up_reject = up_rx_aspm && !(can_accept_l1_i && aspm_l1_enable_i);

    pm_idle_timer u_idle_timer (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .run_i(down && in_l0 && link_idle_i && (state == pm_entry_pkg::NEG_IDLE)),
        .expired_o(idle_expired)
    );

    pm_idle_timer u_l0s_timer (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .run_i(down && rx_l0s_i && tx_l0s_i && (state == pm_entry_pkg::NEG_IDLE)),
        .expired_o(l0s_expired)
    );

    always_comb begin
        next_state = state;
        next_aspm_mode = aspm_mode;
        next_tlp_held = tlp_held;
        case (state)
            pm_entry_pkg::NEG_IDLE: begin
                // Downstream restarts from idle; upstream only reacts
                if (down_start_l23 && in_l0) begin
                    next_state = pm_entry_pkg::NEG_SEND_L23;
                end else if (down_start_l1 && in_l0) begin
                    next_state = pm_entry_pkg::NEG_SEND_L1;
                    next_aspm_mode = !pcipm_l1_req_i;
                end else if (up_rx_aspm && !up_reject) begin
                    next_state = pm_entry_pkg::NEG_IN_L1;
                end else if (up_rx_pm) begin
                    next_state = rx_enter_l23_i ? pm_entry_pkg::NEG_IN_L23
                                                : pm_entry_pkg::NEG_IN_L1;
                end
            end
            pm_entry_pkg::NEG_SEND_L1: begin
                if (aspm_mode && rx_aspm_nak_i) begin
                    next_state = pm_entry_pkg::NEG_IDLE;
                end else if (rx_request_ack_i) begin
                    next_state = pm_entry_pkg::NEG_ACK_WAIT;
                end
            end
            pm_entry_pkg::NEG_SEND_L23: begin
                if (rx_request_ack_i) begin
                    next_state = pm_entry_pkg::NEG_IN_L23;
                end
            end
            pm_entry_pkg::NEG_ACK_WAIT: begin
                if (l1_reached_i) begin
                    next_state = pm_entry_pkg::NEG_IN_L1;
                end
            end
            pm_entry_pkg::NEG_IN_L1: begin
                // A held TLP forces exit only after L1 is reached
                if (tlp_held && l1_reached_i) begin
                    next_state = pm_entry_pkg::NEG_EXIT;
                end else if (exit_done_i) begin
                    next_state = pm_entry_pkg::NEG_IDLE;
                end
            end
            pm_entry_pkg::NEG_IN_L23: begin
                next_state = pm_entry_pkg::NEG_IN_L23;
            end
            pm_entry_pkg::NEG_EXIT: begin
                if (exit_done_i) begin
                    next_state = pm_entry_pkg::NEG_IDLE;
                end
            end
            default: begin
                next_state = pm_entry_pkg::NEG_IDLE;
            end
        endcase
        if (tlp_pending_i && (state != pm_entry_pkg::NEG_IDLE)) begin
            next_tlp_held = 1'b1;
        end
        if (next_state == pm_entry_pkg::NEG_IDLE) begin
            next_tlp_held = 1'b0;
        end
        if (interrupted && (negotiating || state == pm_entry_pkg::NEG_IN_L1)) begin
            next_state = pm_entry_pkg::NEG_IDLE;
            next_tlp_held = 1'b0;
        end
        if (goto_ldn) begin
            next_state = pm_entry_pkg::NEG_IDLE;
            next_tlp_held = 1'b0;
        end
    end

    // Power state leaves L0 for L1 or L23 Ready only once negotiation completes; LDn is entered at once on reset or disable
    always_comb begin
        next_pwr = pwr;
        if (goto_ldn) begin
            next_pwr = pm_entry_pkg::PWR_LDN;
        end else if (next_state == pm_entry_pkg::NEG_IN_L1 && l1_reached_i) begin
            next_pwr = pm_entry_pkg::PWR_L1;
        end else if (next_state == pm_entry_pkg::NEG_IN_L23) begin
            next_pwr = pm_entry_pkg::PWR_L23_READY;
        end else if (in_l0) begin
            next_pwr = pm_entry_pkg::PWR_L0;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= pm_entry_pkg::NEG_IDLE;
            pwr <= pm_entry_pkg::PWR_L0;
            aspm_mode <= 1'b0;
            tlp_held <= 1'b0;
        end else begin
            state <= next_state;
            pwr <= next_pwr;
            aspm_mode <= next_aspm_mode;
            tlp_held <= next_tlp_held;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_request_ack_o <= 1'b0;
            tx_aspm_nak_o <= 1'b0;
            retrain_o <= 1'b0;
        end else begin
            // Answer in the cycle after the request
            tx_request_ack_o <= (up_rx_aspm && !up_reject && state == pm_entry_pkg::NEG_IDLE)
                                || (up_rx_pm && state == pm_entry_pkg::NEG_IDLE);
            tx_aspm_nak_o <= up_reject;
            retrain_o <= is_upstream_i && retrain_write_i;
        end
    end

    // Entry DLLPs flow for as long as the sending state holds
    assign tx_enter_l1_o = (state == pm_entry_pkg::NEG_SEND_L1) && !aspm_mode;
    assign tx_aspm_req_l1_o = (state == pm_entry_pkg::NEG_SEND_L1) && aspm_mode;
    assign tx_enter_l23_o = (state == pm_entry_pkg::NEG_SEND_L23);
    assign start_exit_o = (state == pm_entry_pkg::NEG_EXIT);
    // TLPs blocked while negotiating or in low power
    assign tlp_go_o = tlp_pending_i && (state == pm_entry_pkg::NEG_IDLE) && in_l0;
    assign pwr_state_o = pwr;
    assign neg_state_o = state;

    property p_reset_idle;
        @(posedge clock_i) $rose(nrst_i) |-> state == pm_entry_pkg::NEG_IDLE;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    property p_down_first;
        @(posedge clock_i) disable iff (!nrst_i)
        (state == pm_entry_pkg::NEG_IDLE && down && in_l0 && down_start_l23 && !goto_ldn
         && !interrupted) |=> tx_enter_l23_o;
    endproperty
    a_down_first: assert property (p_down_first) else $error("no L23 DLLP after idle");

    property p_interrupt;
        @(posedge clock_i) disable iff (!nrst_i)
        (interrupted && negotiating) |=> state == pm_entry_pkg::NEG_IDLE;
    endproperty
    a_interrupt: assert property (p_interrupt) else $error("interruption ignored");

    property p_up_wait;
        @(posedge clock_i) disable iff (!nrst_i)
        (is_upstream_i && state == pm_entry_pkg::NEG_IDLE) |->
        !(tx_enter_l1_o || tx_aspm_req_l1_o || tx_enter_l23_o);
    endproperty
    a_up_wait: assert property (p_up_wait) else $error("upstream sent entry DLLP");

    property p_l23_hold;
        @(posedge clock_i) disable iff (!nrst_i)
        (tx_enter_l23_o && !rx_request_ack_i && !goto_ldn && !interrupted) |=> tx_enter_l23_o;
    endproperty
    a_l23_hold: assert property (p_l23_hold) else $error("L23 DLLP stream paused");

    property p_answer;
        @(posedge clock_i) disable iff (!nrst_i)
        up_rx_aspm |=> (tx_aspm_nak_o || tx_request_ack_o || state != pm_entry_pkg::NEG_IDLE);
    endproperty
    a_answer: assert property (p_answer) else $error("ASPM request unanswered");

    property p_reject;
        @(posedge clock_i) disable iff (!nrst_i)
        up_reject |=> tx_aspm_nak_o && !tx_request_ack_o;
    endproperty
    a_reject: assert property (p_reject) else $error("reject not immediate");

    property p_ldn;
        @(posedge clock_i) disable iff (!nrst_i)
        goto_ldn |=> pwr == pm_entry_pkg::PWR_LDN;
    endproperty
    a_ldn: assert property (p_ldn) else $error("LDn not entered");

    property p_retrain;
        @(posedge clock_i) disable iff (!nrst_i)
        retrain_o |-> $past(retrain_write_i) && $past(is_upstream_i);
    endproperty
    a_retrain: assert property (p_retrain) else $error("retrain without upstream write");

    property p_up_stay;
        @(posedge clock_i) disable iff (!nrst_i)
        (is_upstream_i && state == pm_entry_pkg::NEG_IDLE && !rx_aspm_req_l1_i
         && !rx_enter_l1_i && !rx_enter_l23_i) |=> state == pm_entry_pkg::NEG_IDLE;
    endproperty
    a_up_stay: assert property (p_up_stay) else $error("upstream left idle unasked");

    property p_down_restart;
        @(posedge clock_i) disable iff (!nrst_i)
        ($past(interrupted && negotiating) && state == pm_entry_pkg::NEG_IDLE && down_start_l1
         && !down_start_l23 && in_l0 && !goto_ldn) |=> state == pm_entry_pkg::NEG_SEND_L1;
    endproperty
    a_down_restart: assert property (p_down_restart) else $error("no restart after abort");

    property p_nak_idle;
        @(posedge clock_i) disable iff (!nrst_i)
        (tx_aspm_req_l1_o && rx_aspm_nak_i) |=> state == pm_entry_pkg::NEG_IDLE;
    endproperty
    a_nak_idle: assert property (p_nak_idle) else $error("rejected request kept going");

    property p_neg_in_l0;
        @(posedge clock_i) disable iff (!nrst_i)
        negotiating |-> pwr == pm_entry_pkg::PWR_L0;
    endproperty
    a_neg_in_l0: assert property (p_neg_in_l0) else $error("negotiation outside L0");

    property p_ack_wait;
        @(posedge clock_i) disable iff (!nrst_i)
        (state == pm_entry_pkg::NEG_ACK_WAIT && !l1_reached_i && !interrupted && !goto_ldn)
        |=> state == pm_entry_pkg::NEG_ACK_WAIT;
    endproperty
    a_ack_wait: assert property (p_ack_wait) else $error("left ack wait early");

    property p_exit_after_l1;
        @(posedge clock_i) disable iff (!nrst_i)
        $rose(start_exit_o) |-> $past(l1_reached_i);
    endproperty
    a_exit_after_l1: assert property (p_exit_after_l1) else $error("exit before L1");

    property p_held_exit;
        @(posedge clock_i) disable iff (!nrst_i)
        (state == pm_entry_pkg::NEG_IN_L1 && tlp_held && l1_reached_i
         && !interrupted && !goto_ldn) |=> start_exit_o;
    endproperty
    a_held_exit: assert property (p_held_exit) else $error("held TLP did not start exit");

    property p_l23_pwr;
        @(posedge clock_i) disable iff (!nrst_i)
        (state == pm_entry_pkg::NEG_IN_L23 && !goto_ldn) |=> pwr == pm_entry_pkg::PWR_L23_READY;
    endproperty
    a_l23_pwr: assert property (p_l23_pwr) else $error("L23 state without L23 power");

    property p_retrain_up;
        @(posedge clock_i) disable iff (!nrst_i)
        (is_upstream_i && retrain_write_i) |=> retrain_o;
    endproperty
    a_retrain_up: assert property (p_retrain_up) else $error("upstream retrain write lost");

    property p_recovery_l0;
        @(posedge clock_i) disable iff (!nrst_i)
        (ltssm_i == pm_entry_pkg::PHY_RECOVERY && !fundamental_reset_i && negotiating
         && !rx_request_ack_i && !l1_reached_i) |=> pwr == pm_entry_pkg::PWR_L0;
    endproperty
    a_recovery_l0: assert property (p_recovery_l0) else $error("Recovery left L0");

endmodule

`default_nettype wire

/* File: include/pm_entry_pkg.sv */
package pm_entry_pkg;

    // Power management state as seen by the link
    typedef enum logic [3:0] {
        PWR_L0 = 4'h1,
        PWR_L1 = 4'h2,
        PWR_L23_READY = 4'h4,
        PWR_LDN = 4'h8
    } pwr_state_type;

    // Negotiation machine states, one-hot
    typedef enum logic [6:0] {
        NEG_IDLE = 7'h01,
        NEG_SEND_L1 = 7'h02,
        NEG_SEND_L23 = 7'h04,
        NEG_ACK_WAIT = 7'h08,
        NEG_IN_L1 = 7'h10,
        NEG_IN_L23 = 7'h20,
        NEG_EXIT = 7'h40
    } neg_state_type;

    // Physical layer state codes presented on ltssm_i
    localparam logic [2:0] PHY_DETECT = 3'h0;
    localparam logic [2:0] PHY_CONFIG = 3'h1;
    localparam logic [2:0] PHY_L0 = 3'h2;
    localparam logic [2:0] PHY_RECOVERY = 3'h3;
    localparam logic [2:0] PHY_DISABLED = 3'h4;
    localparam logic [2:0] PHY_HOT_RESET = 3'h5;

    // Idle time before downstream L1 request
    localparam int IDLE_TIME_NS = 10000;
    localparam int CLK_PERIOD_NS = 20;
    localparam int IDLE_CYCLES = IDLE_TIME_NS / CLK_PERIOD_NS;
    localparam int IDLE_CNT_W = 10;
    localparam logic [IDLE_CNT_W-1:0] IDLE_LIMIT = IDLE_CNT_W'(IDLE_CYCLES - 1);
    localparam logic [IDLE_CNT_W-1:0] IDLE_ZERO = 10'h000;

endpackage

/* File: core/pm_idle_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// Counts cycles a condition holds; expires once the limit is reached
module pm_idle_timer (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Condition
    input wire logic run_i,
    output logic expired_o
);

    logic [pm_entry_pkg::IDLE_CNT_W-1:0] count;
    wire at_limit = (count == pm_entry_pkg::IDLE_LIMIT);

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count <= pm_entry_pkg::IDLE_ZERO;
        end else if (!run_i) begin
            count <= pm_entry_pkg::IDLE_ZERO;
        end else if (!at_limit) begin
            count <= count + 1'b1;
        end
    end

    assign expired_o = run_i && at_limit;

endmodule

`default_nettype wire

/* File: test/pm_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none

// Far end of the link: acknowledges entry DLLPs after a set delay
module pm_link_partner (
    // Clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // Entry DLLPs seen on the link, and the Recovery interrupt
    input wire logic tx_enter_l1_i,
    input wire logic tx_enter_l23_i,
    input wire logic tx_aspm_req_l1_i,
    input wire logic interrupt_i,
    // Commands from the bench
    input wire logic send_aspm_i,
    input wire logic send_enter_i,
    input wire logic [7:0] ack_delay_i,
    // DLLPs sent back
    output logic rx_request_ack_o,
    output logic rx_aspm_req_l1_o,
    output logic rx_enter_l1_o
);
    logic [7:0] wait_count;
    logic acked;
    wire asking = tx_enter_l1_i | tx_enter_l23_i | tx_aspm_req_l1_i;
    wire ack_now = !acked && wait_count == ack_delay_i;

    assign rx_aspm_req_l1_o = send_aspm_i;
    assign rx_enter_l1_o = send_enter_i;

    always_ff @(negedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wait_count <= 8'h00;
            acked <= 1'b0;
            rx_request_ack_o <= 1'b0;
        end else if (interrupt_i || !asking) begin
            wait_count <= 8'h00;
            acked <= 1'b0;
            rx_request_ack_o <= 1'b0;
        end else begin
            rx_request_ack_o <= ack_now;
            acked <= acked | ack_now;
            wait_count <= wait_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: test/link_pm_entry_negotiation_test.sv */
`timescale 1ns/1ps
`default_nettype none

module link_pm_entry_negotiation_test;
    logic clock_i, nrst_i, is_up, aspm_en, can_acc, pcipm_req, l23_req, link_up, irq, f_rst;
    logic link_idle, l1_reached, exit_done, tlp_pending, retrain_wr, send_aspm, send_enter;
    logic [2:0] ltssm;
    logic [7:0] delay;
    logic rx_ack, rx_aspm, rx_l1, tlp_go, retrain, t_l1, t_aspm, t_l23, t_ack, t_nak, st_exit;
    logic rx_nak, rx_l23, rx_l0s, tx_l0s;
    logic [3:0] pwr;
    logic [6:0] neg;
    int failures, check_count;

    pm_entry_fsm uut (.clock_i(clock_i), .nrst_i(nrst_i), .is_upstream_i(is_up),
        .aspm_l1_enable_i(aspm_en), .can_accept_l1_i(can_acc), .pcipm_l1_req_i(pcipm_req),
        .l23_req_i(l23_req), .ltssm_i(ltssm), .link_up_i(link_up), .recovery_irq_i(irq),
        .fundamental_reset_i(f_rst), .link_idle_i(link_idle), .rx_l0s_i(rx_l0s),
        .tx_l0s_i(tx_l0s),
        .l1_reached_i(l1_reached), .exit_done_i(exit_done), .rx_enter_l1_i(rx_l1),
        .rx_aspm_req_l1_i(rx_aspm), .rx_enter_l23_i(rx_l23), .rx_request_ack_i(rx_ack),
        .rx_aspm_nak_i(rx_nak), .tlp_pending_i(tlp_pending), .tlp_go_o(tlp_go),
        .retrain_write_i(retrain_wr), .retrain_o(retrain), .tx_enter_l1_o(t_l1),
        .tx_aspm_req_l1_o(t_aspm), .tx_enter_l23_o(t_l23), .tx_request_ack_o(t_ack),
        .tx_aspm_nak_o(t_nak), .start_exit_o(st_exit), .pwr_state_o(pwr), .neg_state_o(neg));

    pm_link_partner far_end (.clock_i(clock_i), .nrst_i(nrst_i), .tx_enter_l1_i(t_l1),
        .tx_enter_l23_i(t_l23), .tx_aspm_req_l1_i(t_aspm), .interrupt_i(irq),
        .send_aspm_i(send_aspm), .send_enter_i(send_enter), .ack_delay_i(delay),
        .rx_request_ack_o(rx_ack), .rx_aspm_req_l1_o(rx_aspm), .rx_enter_l1_o(rx_l1));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic step(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_vec(input string what, input logic [6:0] exp, input logic [6:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait; a missed state is reported as a mismatch
    task automatic wait_state(input logic [6:0] exp, input int limit);
        int n;
        n = 0;
        while (neg !== exp && n < limit) begin
            step(1);
            n++;
        end
        check_vec("neg_state", exp, neg);
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        step(1);
        sig = 1'b0;
    endtask

    task automatic do_reset;
        nrst_i = 1'b0;
        step(16);
        nrst_i = 1'b1;
        check_vec("neg_state", pm_entry_pkg::NEG_IDLE, neg);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_L0}, {3'h0, pwr});
    endtask

    task automatic test_l23;
        delay = 8'h06;
        l23_req = 1'b1;
        step(1);
        l23_req = 1'b0;
        check_vec("neg_state", pm_entry_pkg::NEG_SEND_L23, neg);
        step(3);
        check_bit("tx_enter_l23", 1'b1, t_l23);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_L0}, {3'h0, pwr});
        wait_state(pm_entry_pkg::NEG_IN_L23, 20);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_L23_READY}, {3'h0, pwr});
        check_bit("tx_enter_l23", 1'b0, t_l23);
        pulse(f_rst);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_LDN}, {3'h0, pwr});
        do_reset();
        $display("test l23 done");
    endtask

    task automatic test_l1_restart;
        delay = 8'h08;
        pcipm_req = 1'b1;
        step(1);
        check_bit("tx_enter_l1", 1'b1, t_l1);
        ltssm = pm_entry_pkg::PHY_RECOVERY;
        pulse(irq);
        check_vec("neg_state", pm_entry_pkg::NEG_IDLE, neg);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_L0}, {3'h0, pwr});
        ltssm = pm_entry_pkg::PHY_L0;
        wait_state(pm_entry_pkg::NEG_SEND_L1, 4);
        tlp_pending = 1'b1;
        wait_state(pm_entry_pkg::NEG_ACK_WAIT, 20);
        pcipm_req = 1'b0;
        check_bit("tlp_go", 1'b0, tlp_go);
        l1_reached = 1'b1;
        wait_state(pm_entry_pkg::NEG_EXIT, 6);
        check_bit("start_exit", 1'b1, st_exit);
        l1_reached = 1'b0;
        exit_done = 1'b1;
        wait_state(pm_entry_pkg::NEG_IDLE, 6);
        check_bit("tlp_go", 1'b1, tlp_go);
        exit_done = 1'b0;
        tlp_pending = 1'b0;
        do_reset();
        $display("test l1 restart done");
    endtask

    task automatic test_upstream;
        is_up = 1'b1;
        aspm_en = 1'b1;
        can_acc = 1'b1;
        pulse(send_aspm);
        check_bit("tx_request_ack", 1'b1, t_ack);
        check_vec("neg_state", pm_entry_pkg::NEG_IN_L1, neg);
        pulse(irq);
        step(3);
        check_vec("neg_state", pm_entry_pkg::NEG_IDLE, neg);
        check_bit("tx_enter_l1", 1'b0, t_l1);
        can_acc = 1'b0;
        pulse(send_aspm);
        check_bit("tx_aspm_nak", 1'b1, t_nak);
        pulse(send_enter);
        check_bit("tx_request_ack", 1'b1, t_ack);
        tlp_pending = 1'b1;
        step(2);
        check_bit("tlp_go", 1'b0, tlp_go);
        l1_reached = 1'b1;
        wait_state(pm_entry_pkg::NEG_EXIT, 4);
        l1_reached = 1'b0;
        exit_done = 1'b1;
        wait_state(pm_entry_pkg::NEG_IDLE, 4);
        check_bit("tlp_go", 1'b1, tlp_go);
        exit_done = 1'b0;
        tlp_pending = 1'b0;
        pulse(retrain_wr);
        check_bit("retrain", 1'b1, retrain);
        pulse(rx_l23);
        check_bit("tx_request_ack", 1'b1, t_ack);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_L23_READY}, {3'h0, pwr});
        is_up = 1'b0;
        aspm_en = 1'b0;
        do_reset();
        pulse(retrain_wr);
        check_bit("retrain", 1'b0, retrain);
        $display("test upstream done");
    endtask

    // Partner ack held off so the rejection arrives first
    task automatic test_l0s_nak;
        delay = 8'hFF;
        aspm_en = 1'b1;
        {rx_l0s, tx_l0s} = 2'b11;
        wait_state(pm_entry_pkg::NEG_SEND_L1, 600);
        check_bit("tx_aspm_req_l1", 1'b1, t_aspm);
        pulse(rx_nak);
        check_vec("neg_state", pm_entry_pkg::NEG_IDLE, neg);
        check_bit("tx_aspm_req_l1", 1'b0, t_aspm);
        {rx_l0s, tx_l0s} = 2'b00;
        aspm_en = 1'b0;
        $display("test l0s nak done");
    endtask

    task automatic test_idle_and_ldn;
        int n;
        n = 0;
        delay = 8'h04;
        aspm_en = 1'b1;
        link_idle = 1'b1;
        while (t_aspm !== 1'b1 && n < 700) begin
            step(1);
            n++;
        end
        check_bit("idle_window", 1'b1,
            n >= pm_entry_pkg::IDLE_CYCLES - 10 && n <= pm_entry_pkg::IDLE_CYCLES + 10);
        wait_state(pm_entry_pkg::NEG_ACK_WAIT, 12);
        link_idle = 1'b0;
        aspm_en = 1'b0;
        ltssm = pm_entry_pkg::PHY_HOT_RESET;
        step(2);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_LDN}, {3'h0, pwr});
        ltssm = pm_entry_pkg::PHY_DISABLED;
        step(2);
        check_vec("pwr_state", {3'h0, pm_entry_pkg::PWR_LDN}, {3'h0, pwr});
        ltssm = pm_entry_pkg::PHY_L0;
        $display("test idle and ldn done");
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        {nrst_i, is_up, aspm_en, can_acc, pcipm_req, l23_req, irq, f_rst} = 8'h00;
        {link_idle, l1_reached, exit_done, tlp_pending, retrain_wr, send_aspm, send_enter} = 7'h00;
        {rx_nak, rx_l23, rx_l0s, tx_l0s} = 4'h0;
        link_up = 1'b1;
        ltssm = pm_entry_pkg::PHY_L0;
        delay = 8'h04;
        failures = 0;
        check_count = 0;
        step(1);
        do_reset();
        test_l23();
        test_l1_restart();
        test_upstream();
        test_l0s_nak();
        test_idle_and_ldn();
        test_done();
    end
endmodule
`default_nettype wire
